// *** aos_scaler_regs.vh ***
// Object indices, reset values and limits of the analog output scaling stage
`ifndef AOS_SCALER_REGS_VH
`define AOS_SCALER_REGS_VH

// ==========================================================
// Object indices
`define AOS_IDX_DEC_PV        16'h6302
`define AOS_IDX_DEC_FV        16'h6332
`define AOS_IDX_FAULT_MODE    16'h6340
`define AOS_IDX_PROCESS_VALUE 16'h7300
`define AOS_IDX_IN_LOW        16'h7320
`define AOS_IDX_OUT_LOW       16'h7321
`define AOS_IDX_IN_HIGH       16'h7322
`define AOS_IDX_OUT_HIGH      16'h7323
`define AOS_IDX_FIELD_RESULT  16'h7330
`define AOS_IDX_FAULT_FV      16'h7341

// ==========================================================
// Sub-indices
`define AOS_SUB_COUNT         8'h00
`define AOS_SUB_CH0           8'h01
`define AOS_SUB_CH1           8'h02
`define AOS_NUM_ENTRIES       16'h0002

// ==========================================================
// Reset values
`define AOS_RST_IN_LOW        16'h0000
`define AOS_RST_OUT_LOW       16'h0000
`define AOS_RST_IN_HIGH       16'h1388
`define AOS_RST_OUT_HIGH      16'h1388
`define AOS_RST_FAULT_FV      16'h0000
`define AOS_RST_PROCESS_VALUE 16'h0000
`define AOS_RST_FIELD_RESULT  16'h0000
`define AOS_RST_DEC           8'h03
`define AOS_RST_FAULT_MODE    8'h01

// ==========================================================
// Field encodings and limits
`define AOS_DEC_MAX           8'h04
`define AOS_FMODE_HOLD        8'h00
`define AOS_FMODE_PREDEF      8'h01
`define AOS_FMODE_MAX         8'h01

// ==========================================================
// Timing: one quotient bit per clock
`define AOS_DIV_STEPS         6'h22

`endif

// *** aos_scaler.v ***
// Two-channel analog output scaling stage with object dictionary access
//
// How it works
// - Input at or below low point gives low output
// - Input at or above high point gives high output
// - Inverted output span is accepted unchanged
// - Input points use the process-value decimal setting
// - Field values are signed 16-bit, field decimal resolution
// - Result held per channel, read-only, process mapped
// - Result object: two read-only signed entries
// - Fault with predefined mode drives fault value
// - Per-channel fault mode selects fault response
`timescale 1ns/1ns
`include "aos_scaler_regs.vh"

module aos_scaler (
	input  wire        clk_sys,
	input  wire        nrst,
	input  wire        ce,
	input  wire        objReq,
	input  wire        objWrite,
	input  wire [15:0] objIndex,
	input  wire [7:0]  objSub,
	input  wire [15:0] objWdata,
	output reg         objAck,
	output reg         objAbort,
	output reg  [15:0] objRdata,
	input  wire [1:0]  extSelect,
	input  wire [15:0] extValue0,
	input  wire [15:0] extValue1,
	input  wire [1:0]  faultActive,
	output reg  [15:0] fieldValue0,
	output reg  [15:0] fieldValue1,
	output reg  [1:0]  fieldUpdate
);

// ==========================================================
// Configuration store
reg        [15:0] inLow      [0:1];
reg        [15:0] inHigh     [0:1];
reg        [15:0] outLow     [0:1];
reg        [15:0] outHigh    [0:1];
reg        [15:0] faultFv    [0:1];
reg        [15:0] processVal [0:1];
reg        [7:0]  decPv      [0:1];
reg        [7:0]  decFv      [0:1];
reg        [7:0]  faultMode  [0:1];

// ==========================================================
// Object access decode
wire       subIsCh  = (objSub == `AOS_SUB_CH0) || (objSub == `AOS_SUB_CH1);
wire       subIsCnt = (objSub == `AOS_SUB_COUNT);
// Sub-index 2 addresses channel 1; every other sub-index indexes channel 0
wire       wrCh     = (objSub == `AOS_SUB_CH1);
reg        knownIdx;
reg        roIdx;
reg        badValue;
reg [15:0] next_rdata;

always @* begin
	knownIdx   = 1'b1;
	roIdx      = 1'b0;
	badValue   = 1'b0;
	next_rdata = 16'h0000;
	case (objIndex)
		`AOS_IDX_DEC_PV: begin
			next_rdata = {8'h00, decPv[wrCh]};
			badValue   = (objWdata > {8'h00, `AOS_DEC_MAX});
		end
		`AOS_IDX_DEC_FV: begin
			next_rdata = {8'h00, decFv[wrCh]};
			badValue   = (objWdata > {8'h00, `AOS_DEC_MAX});
		end
		`AOS_IDX_FAULT_MODE: begin
			next_rdata = {8'h00, faultMode[wrCh]};
			badValue   = (objWdata > {8'h00, `AOS_FMODE_MAX});
		end
		`AOS_IDX_PROCESS_VALUE: next_rdata = processVal[wrCh];
		`AOS_IDX_IN_LOW:        next_rdata = inLow[wrCh];
		`AOS_IDX_OUT_LOW:       next_rdata = outLow[wrCh];
		`AOS_IDX_IN_HIGH:       next_rdata = inHigh[wrCh];
		`AOS_IDX_OUT_HIGH:      next_rdata = outHigh[wrCh];
		`AOS_IDX_FAULT_FV:      next_rdata = faultFv[wrCh];
		`AOS_IDX_FIELD_RESULT: begin
			next_rdata = wrCh ? fieldValue1 : fieldValue0;
			roIdx      = 1'b1;
		end
		default: knownIdx = 1'b0;
	endcase
	if (subIsCnt)
		next_rdata = `AOS_NUM_ENTRIES;
end

// Sub-index zero is read-only everywhere; result entries are read-only too
wire accessOk = knownIdx && (subIsCnt || subIsCh);
wire writeOk  = accessOk && subIsCh && !roIdx && !badValue;
wire doWrite  = ce && objReq && objWrite && writeOk;

integer i;

// Refused accesses still answer, so the master never waits on a lost request
always @(posedge clk_sys) begin
	if (!nrst) begin
		objAck   <= 1'b0;
		objAbort <= 1'b0;
		objRdata <= 16'h0000;
	end else if (ce) begin
		objAck   <= objReq;
		objAbort <= objReq && (objWrite ? !writeOk : !accessOk);
		objRdata <= (objReq && !objWrite && accessOk) ? next_rdata : 16'h0000;
	end
end

// ==========================================================
// Configuration writes
// A refused write leaves every object untouched; the abort alone reports it
always @(posedge clk_sys) begin
	if (!nrst) begin
		for (i = 0; i < 2; i = i + 1) begin
			inLow[i]      <= `AOS_RST_IN_LOW;
			inHigh[i]     <= `AOS_RST_IN_HIGH;
			outLow[i]     <= `AOS_RST_OUT_LOW;
			outHigh[i]    <= `AOS_RST_OUT_HIGH;
			faultFv[i]    <= `AOS_RST_FAULT_FV;
			processVal[i] <= `AOS_RST_PROCESS_VALUE;
			decPv[i]      <= `AOS_RST_DEC;
			decFv[i]      <= `AOS_RST_DEC;
			faultMode[i]  <= `AOS_RST_FAULT_MODE;
		end
	end else begin
		if (doWrite) begin
			case (objIndex)
				`AOS_IDX_DEC_PV:        decPv[wrCh]      <= objWdata[7:0];
				`AOS_IDX_DEC_FV:        decFv[wrCh]      <= objWdata[7:0];
				`AOS_IDX_FAULT_MODE:    faultMode[wrCh]  <= objWdata[7:0];
				`AOS_IDX_PROCESS_VALUE: processVal[wrCh] <= objWdata;
				`AOS_IDX_IN_LOW:        inLow[wrCh]      <= objWdata;
				`AOS_IDX_OUT_LOW:       outLow[wrCh]     <= objWdata;
				`AOS_IDX_IN_HIGH:       inHigh[wrCh]     <= objWdata;
				`AOS_IDX_OUT_HIGH:      outHigh[wrCh]    <= objWdata;
				`AOS_IDX_FAULT_FV:      faultFv[wrCh]    <= objWdata;
				default: ;
			endcase
		end
	end
end

// ==========================================================
// Scaling engine
// One shared serial divider serves both channels in turn; it trades
// about 36 clocks per channel update for the area of a second divider.
localparam [1:0] ST_PREP = 2'h0;
localparam [1:0] ST_DIV  = 2'h1;
localparam [1:0] ST_DONE = 2'h2;
// The step count starts at zero, so the last step is one below the total
localparam [5:0] LAST_STEP = `AOS_DIV_STEPS - 6'h01;

reg  [1:0]  state;
reg         ch;
reg  [5:0]  stepCnt;
reg  [33:0] divQuo;
reg  [17:0] divRem;
reg  [16:0] divDen;
reg         spanNeg;

// ==========================================================
// Per-channel input selection, clamp and fault detection
// Both points and the input share one decimal setting, so the scale
// cancels in the ratio and the raw integers compare and interpolate directly.
wire [15:0] selIn     [0:1];
wire [1:0]  belowLow;
wire [1:0]  aboveHigh;
wire [1:0]  predefHit;
wire [1:0]  holdHit;

genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : gChan
		assign selIn[g]     = extSelect[g] ? ((g == 0) ? extValue0 : extValue1) : processVal[g];
		assign belowLow[g]  = $signed(selIn[g]) <= $signed(inLow[g]);
		assign aboveHigh[g] = $signed(selIn[g]) >= $signed(inHigh[g]);
		assign predefHit[g] = faultActive[g] && (faultMode[g] == `AOS_FMODE_PREDEF);
		assign holdHit[g]   = faultActive[g] && (faultMode[g] != `AOS_FMODE_PREDEF);
	end
endgenerate

// ==========================================================
// Operands of the channel in turn
wire [15:0] chInput   = selIn[ch];
wire [15:0] lo        = inLow[ch];
wire [15:0] hi        = inHigh[ch];
wire [15:0] oLo       = outLow[ch];
wire [15:0] oHi       = outHigh[ch];
wire        atLow     = belowLow[ch];
wire        atHigh    = aboveHigh[ch];
wire        faultPre  = predefHit[ch];
wire        faultHold = holdHit[ch];
wire [16:0] diffIn  = {chInput[15], chInput} - {lo[15], lo};
wire [16:0] spanIn  = {hi[15], hi} - {lo[15], lo};
wire [16:0] spanOut = {oHi[15], oHi} - {oLo[15], oLo};
wire [16:0] spanMag = spanOut[16] ? (17'h00000 - spanOut) : spanOut;
wire [33:0] prodMag = diffIn * spanMag;

wire [17:0] remSh  = {divRem[16:0], divQuo[33]};
wire        remGe  = remSh >= {1'b0, divDen};
wire [16:0] quoS   = spanNeg ? (17'h00000 - divQuo[16:0]) : divQuo[16:0];
wire [16:0] interp = {oLo[15], oLo} + quoS;

// Fault handling outranks the clamps; a fault arriving mid-divide wins at DONE
reg         next_we;
reg  [15:0] next_result;

always @* begin
	next_we     = 1'b0;
	next_result = oLo;
	if (state == ST_PREP || state == ST_DONE) begin
		if (faultPre) begin
			next_we     = 1'b1;
			next_result = faultFv[ch];
		end else if (faultHold) begin
			next_we = 1'b0;
		end else if (state == ST_DONE) begin
			next_we     = 1'b1;
			next_result = interp[15:0];
		end else if (atLow) begin
			next_we     = 1'b1;
			next_result = oLo;
		end else if (atHigh) begin
			next_we     = 1'b1;
			next_result = oHi;
		end
	end
end

wire startDiv = (state == ST_PREP) && !faultActive[ch] && !atLow && !atHigh;

always @(posedge clk_sys) begin
	if (!nrst) begin
		state       <= ST_PREP;
		ch          <= 1'b0;
		fieldValue0 <= `AOS_RST_FIELD_RESULT;
		fieldValue1 <= `AOS_RST_FIELD_RESULT;
		fieldUpdate <= 2'h0;
	end else if (ce) begin
		fieldUpdate <= 2'h0;
		if (next_we) begin
			if (ch)
				fieldValue1 <= next_result;
			else
				fieldValue0 <= next_result;
			fieldUpdate <= ch ? 2'h2 : 2'h1;
		end
		// A hold-mode fault skips the channel without a write, so it keeps its last value
		case (state)
			ST_PREP: begin
				if (startDiv)
					state <= ST_DIV;
				else
					ch <= ~ch;
			end
			ST_DIV: begin
				if (stepCnt == LAST_STEP)
					state <= ST_DONE;
			end
			ST_DONE: begin
				ch    <= ~ch;
				state <= ST_PREP;
			end
			default: state <= ST_PREP;
		endcase
	end
end

// ==========================================================
// Serial divider: restoring division, one quotient bit per clock
// The dividend leaves the top of divQuo as quotient bits enter at the bottom.
// The divisor is never zero: with equal points every input hits a clamp first.
always @(posedge clk_sys) begin
	if (!nrst) begin
		stepCnt <= 6'h00;
		divQuo  <= 34'h000000000;
		divRem  <= 18'h00000;
		divDen  <= 17'h00000;
		spanNeg <= 1'b0;
	end else if (ce) begin
		if (startDiv) begin
			divQuo  <= prodMag;
			divRem  <= 18'h00000;
			divDen  <= spanIn;
			spanNeg <= spanOut[16];
			stepCnt <= 6'h00;
		end else if (state == ST_DIV) begin
			divRem  <= remGe ? (remSh - {1'b0, divDen}) : remSh;
			divQuo  <= {divQuo[32:0], remGe};
			stepCnt <= stepCnt + 6'h01;
		end
	end
end

endmodule // aos_scaler

// *** aos_scaler_props.sv ***
// Port checker for the analog output scaling stage
`timescale 1ns/1ns
module aos_scaler_props (
	input logic        clk_sys,
	input logic        nrst,
	input logic        ce,
	input logic        objReq,
	input logic        objWrite,
	input logic [15:0] objIndex,
	input logic [7:0]  objSub,
	input logic        objAck,
	input logic        objAbort,
	input logic [15:0] objRdata,
	input logic [15:0] fieldValue0,
	input logic [1:0]  fieldUpdate
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Access steps
	sequence taken; ce && objReq; endsequence
	sequence resWrite; taken ##0 objWrite && objIndex == 16'h7330; endsequence
	sequence countRead; taken ##0 !objWrite && objIndex == 16'h7330 && objSub == 8'h00; endsequence
	ack_latency_a: assert property (taken |=> objAck) else $error("no ack after request");
	ack_cause_a: assert property ($rose(objAck) |-> $past(ce && objReq)) else $error("ack without request");
	abort_zero_a: assert property (objAbort |-> objAck && objRdata == 16'h0000) else $error("bad abort");
	result_ro_a: assert property (resWrite |=> objAbort) else $error("result write taken");
	entry_count_a: assert property (countRead |=> objRdata == 16'h0002 && !objAbort) else $error("bad count");
	sub_range_a: assert property (taken ##0 objSub > 8'h02 |=> objAbort) else $error("bad sub taken");
	field_change_a: assert property ($changed(fieldValue0) |-> fieldUpdate[0]) else $error("silent change");
	update_pulse_a: assert property (ce && fieldUpdate[0] |=> !fieldUpdate[0]) else $error("long update");
	freeze_hold_a: assert property (nrst && !ce |=> $stable(objAck) && $stable(fieldValue0) && $stable(fieldUpdate))
		else $error("state moved while frozen");
endmodule // aos_scaler_props

bind aos_scaler aos_scaler_props chk (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .objReq(objReq),
	.objWrite(objWrite), .objIndex(objIndex), .objSub(objSub), .objAck(objAck), .objAbort(objAbort),
	.objRdata(objRdata), .fieldValue0(fieldValue0), .fieldUpdate(fieldUpdate));

// *** aos_master.sv ***
// Network master model driving the object access port
`timescale 1ns/1ns
module aos_master (
	input  logic        clk_sys,
	output logic        objReq,
	output logic        objWrite,
	output logic [15:0] objIndex,
	output logic [7:0]  objSub,
	output logic [15:0] objWdata
);
	initial begin
		objReq = 1'b0;
		objWrite = 1'b0;
		objIndex = 16'h0000;
		objSub = 8'h00;
		objWdata = 16'h0000;
	end
	// ==========================================================
	// One access; input points stay at their ordered defaults
	task xfer(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [15:0] d);
		@(posedge clk_sys);
		objReq <= 1'b1;
		objWrite <= w;
		objIndex <= i;
		objSub <= s;
		objWdata <= d;
		@(posedge clk_sys);
		// Released lines show the inverse so stale values never match
		objReq <= 1'b0;
		objIndex <= ~i;
		objSub <= ~s;
		objWdata <= ~d;
		@(posedge clk_sys);
	endtask
endmodule // aos_master

// *** aos_tb.sv ***
// Self-checking bench for the analog output scaling stage
`timescale 1ns/1ns
module tb_top;
	logic        clk_sys, nrst, ce, objReq, objWrite, objAck, objAbort;
	logic [1:0]  extSelect, faultActive, fieldUpdate;
	logic [15:0] extValue0, extValue1, fieldValue0, fieldValue1, objIndex, objWdata, objRdata, v, e;
	logic [7:0]  objSub;
	logic [16:0] expQ[$];
	int          mismatches, nTests, cyc, k;
	integer      seed = 32'h1f38;
	aos_master m (.clk_sys(clk_sys), .objReq(objReq), .objWrite(objWrite), .objIndex(objIndex),
		.objSub(objSub), .objWdata(objWdata));
	aos_scaler uut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .objReq(objReq), .objWrite(objWrite),
		.objIndex(objIndex), .objSub(objSub), .objWdata(objWdata), .objAck(objAck), .objAbort(objAbort),
		.objRdata(objRdata), .extSelect(extSelect), .extValue0(extValue0), .extValue1(extValue1),
		.faultActive(faultActive), .fieldValue0(fieldValue0), .fieldValue1(fieldValue1),
		.fieldUpdate(fieldUpdate));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// ==========================================================
	// Checking
	task chk(input logic [16:0] seen, input logic [16:0] exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		if (mismatches == 0 && nTests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [15:0] d,
		input logic ab, input logic [15:0] x);
		expQ.push_back({ab, x});
		m.xfer(w, i, s, d);
	endtask
	// Second update of a channel is the first sure to be computed from the new inputs
	task waitUpd(input int c);
		repeat (2) begin
			@(posedge clk_sys);
			while (fieldUpdate[c] !== 1'b1) @(posedge clk_sys);
		end
	endtask
	always @(posedge clk_sys) if (objAck === 1'b1) chk({objAbort, objRdata}, expQ.pop_front());
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			report_and_stop;
		end
	end
	// ==========================================================
	// Scenarios
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		extSelect = 2'b11;
		faultActive = 2'b00;
		extValue0 = 16'h0000;
		extValue1 = 16'h0100;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		acc(0, 16'h7321, 8'h01, 16'h0000, 0, 16'h0000);
		acc(0, 16'h7322, 8'h02, 16'h0000, 0, 16'h1388);
		acc(0, 16'h7341, 8'h02, 16'h0000, 0, 16'h0000);
		acc(0, 16'h7330, 8'h00, 16'h0000, 0, 16'h0002);
		acc(1, 16'h7330, 8'h01, 16'h0055, 1, 16'h0000);
		acc(0, 16'h7330, 8'h03, 16'h0000, 1, 16'h0000);
		acc(1, 16'h6302, 8'h01, 16'h0005, 1, 16'h0000);
		acc(1, 16'h6302, 8'h01, 16'h0004, 0, 16'h0000);
		acc(0, 16'h6302, 8'h01, 16'h0000, 0, 16'h0004);
		acc(1, 16'h7323, 8'h01, 16'h2710, 0, 16'h0000);
		for (k = 0; k < 4; k++) begin
			v = {$random(seed)} % 16'h1388;
			if (k == 3) begin
				acc(1, 16'h7321, 8'h01, 16'h2710, 0, 16'h0000);
				acc(1, 16'h7323, 8'h01, 16'h0000, 0, 16'h0000);
			end
			extValue0 <= (k == 0) ? -v : (k == 1) ? v + 16'h1388 : v;
			e = (k == 0) ? 16'h0000 : (k == 1) ? 16'h2710 : (k == 2) ? v + v : 16'h2710 - v - v;
			waitUpd(0);
			chk(fieldValue0, e);
			acc(0, 16'h7330, 8'h01, 16'h0000, 0, e);
		end
		acc(1, 16'h7341, 8'h02, 16'h1234, 0, 16'h0000);
		faultActive <= 2'b10;
		waitUpd(1);
		chk(fieldValue1, 16'h1234);
		acc(0, 16'h7330, 8'h02, 16'h0000, 0, 16'h1234);
		acc(1, 16'h6340, 8'h02, 16'h0002, 1, 16'h0000);
		acc(1, 16'h6340, 8'h02, 16'h0000, 0, 16'h0000);
		acc(1, 16'h7341, 8'h02, 16'h4321, 0, 16'h0000);
		repeat (80) @(posedge clk_sys);
		acc(0, 16'h7330, 8'h02, 16'h0000, 0, 16'h1234);
		acc(1, 16'h7300, 8'h01, 16'h0FA0, 0, 16'h0000);
		extSelect <= 2'b10;
		waitUpd(0);
		chk(fieldValue0, 16'h07D0);
		acc(0, 16'h7330, 8'h01, 16'h0000, 0, 16'h07D0);
		ce <= 1'b0;
		m.xfer(1, 16'h7341, 8'h02, 16'h5555);
		ce <= 1'b1;
		acc(0, 16'h7341, 8'h02, 16'h0000, 0, 16'h4321);
		repeat (2) @(posedge clk_sys);
		chk(17'(expQ.size()), 17'h00000);
		report_and_stop;
	end
endmodule // tb_top
